/* File: design/tare_overpressure_unit.sv */
// Tare and overpressure post-processing of pressure samples
`timescale 1ns/1ps
module tare_overpressure_unit #(
  parameter int                     DW          = tare_pkg::DATA_W,
  parameter logic signed [DW-1:0]   SP_DEFAULT  = tare_pkg::SP_MAX
) (
  input  wire logic                         clk_sys,
  input  wire logic                         rst,
  input  wire logic                         nv_init,
  input  wire logic                         wb_cyc_i,
  input  wire logic                         wb_stb_i,
  input  wire logic                         wb_we_i,
  input  wire logic [tare_pkg::ADR_W-1:0]   wb_adr_i,
  input  wire logic [3:0]                   wb_sel_i,
  input  wire logic [DW-1:0]                wb_dat_i,
  output logic      [DW-1:0]                wb_dat_o,
  output logic                              wb_ack_o,
  input  wire logic                         sample_valid,
  input  wire logic signed [DW-1:0]         sample_data,
  input  wire logic                         pressure_read_cmd_a,
  input  wire logic                         pressure_read_cmd_b,
  input  wire logic                         tare_line,
  output logic                              out_valid,
  output logic signed [DW-1:0]              out_data,
  output logic                              tare_mark,
  output logic                              overpressure
);

  // ****************************************
  // Parameter check
  // ****************************************
  if (DW != tare_pkg::DATA_W)
  begin : g_dw_chk
    $error("DW must equal the package data width");
  end

  // ****************************************
  // Declarations
  // ****************************************
  logic                            wr_stb;
  logic [tare_pkg::ADR_W-1:0]      wr_adr;
  logic [DW-1:0]                   wr_dat;
  logic [DW-1:0]                   rd_dat;
  tare_pkg::tare_state_t           tare_state_q;
  logic signed [DW-1:0]            tare_offset_q;
  logic signed [DW-1:0]            nv_offset_q;
  logic                            tare_persist_sel_q;
  logic                            tare_lockout_q;
  logic                            tare_indicate_en_q;
  logic [tare_pkg::MODE_W-1:0]     continuous_output_mode_q;
  logic signed [DW-1:0]            overpressure_setpoint_q;
  logic signed [DW-1:0]            unit_ratio_q;
  logic signed [DW-1:0]            scaled_sp;
  logic                            check_pend_q;
  logic                            out_valid_q;
  logic signed [DW-1:0]            out_data_q;
  logic                            tare_mark_q;
  logic                            over_q;
  logic                            wr_state;
  logic                            host_req;
  logic                            host_off;
  logic                            capture;
  logic                            check_now;
  logic signed [DW-1:0]            corrected;

  // ****************************************
  // Bus port
  // ****************************************
  wb_reg_port u_port (
    .clk_sys  (clk_sys),
    .rst      (rst),
    .wb_cyc_i (wb_cyc_i),
    .wb_stb_i (wb_stb_i),
    .wb_we_i  (wb_we_i),
    .wb_adr_i (wb_adr_i),
    .wb_sel_i (wb_sel_i),
    .wb_dat_i (wb_dat_i),
    .wb_dat_o (wb_dat_o),
    .wb_ack_o (wb_ack_o),
    .wr_stb   (wr_stb),
    .wr_adr   (wr_adr),
    .wr_dat   (wr_dat),
    .rd_dat   (rd_dat)
  );

  // ****************************************
  // Tare request decode
  // ****************************************
  assign wr_state  = wr_stb && (wr_adr == tare_pkg::ADR_STATE);
  assign host_req  = ((wr_state && wr_dat == tare_pkg::WR_TARE_REQ) || tare_line)
                     && !tare_lockout_q;
  assign host_off  = wr_state && (wr_dat == tare_pkg::WR_TARE_OFF) && !tare_lockout_q;
  assign capture   = sample_valid && (tare_state_q == tare_pkg::TARE_REQ);
  assign corrected = (tare_state_q == tare_pkg::TARE_APPLIED) ?
                     sample_data - tare_offset_q : sample_data;

  // ****************************************
  // Tare state
  // ****************************************
  always_ff @(posedge clk_sys)
  begin
    if (rst)
      tare_state_q <= tare_pkg::TARE_OFF;
    else if (host_req)
      tare_state_q <= tare_pkg::TARE_REQ;
    else if (host_off)
      tare_state_q <= tare_pkg::TARE_OFF;
    else if (capture)
      tare_state_q <= tare_pkg::TARE_APPLIED;
  end

  // ****************************************
  // Tare offset and its retained copy
  // ****************************************
  always_ff @(posedge clk_sys)
  begin
    if (rst)
      tare_offset_q <= tare_persist_sel_q ? nv_offset_q : tare_pkg::RESET_ZERO;
    else if (capture)
      tare_offset_q <= sample_data;
    else if (wr_stb && wr_adr == tare_pkg::ADR_OFFSET
             && tare_state_q == tare_pkg::TARE_APPLIED
             && tare_pkg::in_range(wr_dat, tare_pkg::OFFSET_MIN, tare_pkg::OFFSET_MAX))
      tare_offset_q <= wr_dat;
  end

  always_ff @(posedge clk_sys)
  begin
    if (nv_init)
      nv_offset_q <= tare_pkg::RESET_ZERO;
    else if (!rst)
      nv_offset_q <= tare_offset_q;
  end

  always_ff @(posedge clk_sys)
  begin
    if (nv_init)
      tare_persist_sel_q <= 1'b0;
    else if (wr_stb && wr_adr == tare_pkg::ADR_PERSIST)
      tare_persist_sel_q <= wr_dat[0];
  end

  // ****************************************
  // Lockout, indication and mode
  // ****************************************
  always_ff @(posedge clk_sys)
  begin
    if (rst)
      tare_lockout_q <= 1'b0;
    else if (wr_stb && wr_adr == tare_pkg::ADR_LOCKOUT)
      tare_lockout_q <= wr_dat[0];
  end

  always_ff @(posedge clk_sys)
  begin
    if (rst)
      tare_indicate_en_q <= 1'b0;
    else if (wr_stb && wr_adr == tare_pkg::ADR_INDICATE)
      tare_indicate_en_q <= wr_dat[0];
  end

  always_ff @(posedge clk_sys)
  begin
    if (rst)
      continuous_output_mode_q <= '0;
    else if (wr_stb && wr_adr == tare_pkg::ADR_MODE)
      continuous_output_mode_q <= wr_dat[tare_pkg::MODE_W-1:0];
  end

  // ****************************************
  // Set-point and unit rescaling
  // ****************************************
  setpoint_rescale #(
    .DW (DW)
  ) u_rescale (
    .setpoint (overpressure_setpoint_q),
    .ratio    ($signed(wr_dat)),
    .scaled   (scaled_sp)
  );

  always_ff @(posedge clk_sys)
  begin
    if (rst)
      overpressure_setpoint_q <= SP_DEFAULT;
    else if (wr_stb && wr_adr == tare_pkg::ADR_SETPOINT
             && tare_pkg::in_range(wr_dat, tare_pkg::SP_MIN, tare_pkg::SP_MAX))
      overpressure_setpoint_q <= wr_dat;
    else if (wr_stb && wr_adr == tare_pkg::ADR_UNIT && !wr_dat[DW-1] && wr_dat != '0)
      overpressure_setpoint_q <= scaled_sp;
  end

  always_ff @(posedge clk_sys)
  begin
    if (rst)
      unit_ratio_q <= tare_pkg::SCALE_ONE;
    else if (wr_stb && wr_adr == tare_pkg::ADR_UNIT && !wr_dat[DW-1] && wr_dat != '0)
      unit_ratio_q <= wr_dat;
  end

  // ****************************************
  // Sample path and comparison
  // ****************************************
  assign check_now = (continuous_output_mode_q != '0) || check_pend_q
                     || pressure_read_cmd_a || pressure_read_cmd_b;

  always_ff @(posedge clk_sys)
  begin
    if (rst)
      check_pend_q <= 1'b0;
    else if (sample_valid)
      check_pend_q <= 1'b0;
    else if (pressure_read_cmd_a || pressure_read_cmd_b)
      check_pend_q <= 1'b1;
  end

  always_ff @(posedge clk_sys)
  begin
    if (rst)
      out_valid_q <= 1'b0;
    else
      out_valid_q <= sample_valid;
  end

  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      out_data_q  <= tare_pkg::RESET_ZERO;
      tare_mark_q <= 1'b0;
    end
    else if (sample_valid)
    begin
      out_data_q  <= corrected;
      tare_mark_q <= tare_indicate_en_q
                     && tare_state_q == tare_pkg::TARE_APPLIED;
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (rst)
      over_q <= 1'b0;
    else if (sample_valid && check_now)
      over_q <= corrected >= overpressure_setpoint_q;
  end

  assign out_valid    = out_valid_q;
  assign out_data     = out_data_q;
  assign tare_mark    = tare_mark_q;
  assign overpressure = over_q;

  // ****************************************
  // Read mux
  // ****************************************
  always_comb
  begin
    rd_dat = '0;
    unique case (wb_adr_i)
      tare_pkg::ADR_STATE:    rd_dat = {{(DW-2){1'b0}}, tare_state_q};
      tare_pkg::ADR_OFFSET:   rd_dat = tare_offset_q;
      tare_pkg::ADR_LOCKOUT:  rd_dat[0] = tare_lockout_q;
      tare_pkg::ADR_PERSIST:  rd_dat[0] = tare_persist_sel_q;
      tare_pkg::ADR_SETPOINT: rd_dat = overpressure_setpoint_q;
      tare_pkg::ADR_MODE:     rd_dat[tare_pkg::MODE_W-1:0] = continuous_output_mode_q;
      tare_pkg::ADR_INDICATE: rd_dat[0] = tare_indicate_en_q;
      tare_pkg::ADR_UNIT:     rd_dat = unit_ratio_q;
      tare_pkg::ADR_STATUS:
      begin
        rd_dat[tare_pkg::ST_OVER_BIT] = over_q;
        rd_dat[tare_pkg::ST_MARK_BIT] = tare_mark_q;
      end
      tare_pkg::ADR_SAMPLE:   rd_dat = out_data_q;
      default:                rd_dat = '0;
    endcase
  end

  // ****************************************
  // Assertions
  // ****************************************
  property p_reset_state;
    @(posedge clk_sys)
    rst |=> tare_state_q == tare_pkg::TARE_OFF && !tare_lockout_q;
  endproperty
  a_reset_state: assert property (p_reset_state) else $error("reset state wrong");

  property p_request;
    @(posedge clk_sys) disable iff (rst)
    wr_state && wr_dat == tare_pkg::WR_TARE_REQ && !tare_lockout_q
    |=> tare_state_q == tare_pkg::TARE_REQ;
  endproperty
  a_request: assert property (p_request) else $error("request not pending");

  property p_capture;
    @(posedge clk_sys) disable iff (rst)
    capture && !host_req && !host_off
    |=> tare_state_q == tare_pkg::TARE_APPLIED && tare_offset_q == $past(sample_data);
  endproperty
  a_capture: assert property (p_capture) else $error("capture failed");

  property p_subtract;
    @(posedge clk_sys) disable iff (rst)
    sample_valid && tare_state_q == tare_pkg::TARE_APPLIED
    |=> out_valid && out_data == $past(sample_data) - $past(tare_offset_q);
  endproperty
  a_subtract: assert property (p_subtract) else $error("tare not subtracted");

  property p_pass;
    @(posedge clk_sys) disable iff (rst)
    sample_valid && tare_state_q == tare_pkg::TARE_OFF |=> out_data == $past(sample_data);
  endproperty
  a_pass: assert property (p_pass) else $error("sample altered while off");

  property p_state_legal;
    @(posedge clk_sys) disable iff (rst)
    tare_state_q != 2'h3;
  endproperty
  a_state_legal: assert property (p_state_legal) else $error("illegal tare state");

  property p_lockout;
    @(posedge clk_sys) disable iff (rst)
    tare_lockout_q && !sample_valid |=> $stable(tare_state_q);
  endproperty
  a_lockout: assert property (p_lockout) else $error("state changed under lockout");

  property p_over;
    @(posedge clk_sys) disable iff (rst)
    sample_valid && continuous_output_mode_q != '0
    |=> overpressure == ($past(corrected) >= $past(overpressure_setpoint_q));
  endproperty
  a_over: assert property (p_over) else $error("overpressure wrong");

  property p_no_check;
    @(posedge clk_sys) disable iff (rst)
    !check_now |=> $stable(overpressure);
  endproperty
  a_no_check: assert property (p_no_check) else $error("compare ran unasked");

  property p_ack_pulse;
    @(posedge clk_sys) disable iff (rst)
    wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o;
  endproperty
  a_ack_pulse: assert property (p_ack_pulse) else $error("ack timing wrong");

  property p_capture_seen;
    @(posedge clk_sys) disable iff (rst)
    tare_state_q == tare_pkg::TARE_REQ ##1 tare_state_q == tare_pkg::TARE_APPLIED;
  endproperty
  c_capture_seen: cover property (p_capture_seen);

  property p_over_rise;
    @(posedge clk_sys) disable iff (rst)
    $rose(overpressure);
  endproperty
  c_over_rise: cover property (p_over_rise);

  property p_lock_complete;
    @(posedge clk_sys) disable iff (rst)
    tare_lockout_q && capture;
  endproperty
  c_lock_complete: cover property (p_lock_complete);

endmodule

/* File: design/tare_pkg.sv */
// Shared constants, types and helpers for the tare and overpressure unit
package tare_pkg;

  // ****************************************
  // Widths and register byte offsets
  // ****************************************
  localparam int          DATA_W       = 32;
  localparam int          ADR_W        = 8;
  localparam logic [7:0]  ADR_STATE    = 8'h00;
  localparam logic [7:0]  ADR_OFFSET   = 8'h04;
  localparam logic [7:0]  ADR_LOCKOUT  = 8'h08;
  localparam logic [7:0]  ADR_PERSIST  = 8'h0c;
  localparam logic [7:0]  ADR_SETPOINT = 8'h10;
  localparam logic [7:0]  ADR_MODE     = 8'h14;
  localparam logic [7:0]  ADR_INDICATE = 8'h18;
  localparam logic [7:0]  ADR_UNIT     = 8'h1c;
  localparam logic [7:0]  ADR_STATUS   = 8'h20;
  localparam logic [7:0]  ADR_SAMPLE   = 8'h24;
  localparam logic [3:0]  SEL_ALL      = 4'hf;

  // ****************************************
  // Field positions and values
  // ****************************************
  localparam int          ST_OVER_BIT  = 0;
  localparam int          ST_MARK_BIT  = 1;
  localparam int          MODE_W       = 4;
  localparam logic [31:0] WR_TARE_OFF  = 32'h0000_0000;
  localparam logic [31:0] WR_TARE_REQ  = 32'h0000_0001;
  localparam logic [31:0] RESET_ZERO   = 32'h0000_0000;
  localparam logic [31:0] SCALE_ONE    = 32'h0001_0000;
  localparam int          SCALE_SHIFT  = 16;

  // ****************************************
  // Value ranges
  // ****************************************
  localparam logic signed [31:0] OFFSET_MIN = 32'shff67_6981;
  localparam logic signed [31:0] OFFSET_MAX = 32'sh0098_967f;
  localparam logic signed [31:0] SP_MIN     = 32'shfa0a_1f01;
  localparam logic signed [31:0] SP_MAX     = 32'sh0098_967f;

  typedef enum logic [1:0] {TARE_OFF, TARE_REQ, TARE_APPLIED} tare_state_t;

  // Range test for signed values
  function automatic logic in_range(input logic signed [31:0] v,
                                    input logic signed [31:0] lo,
                                    input logic signed [31:0] hi);
    in_range = (v >= lo) && (v <= hi);
  endfunction

endpackage

/* File: design/wb_reg_port.sv */
// Classic Wishbone slave that turns bus cycles into write strobes and reads
`timescale 1ns/1ps
module wb_reg_port (
  input  wire logic                         clk_sys,
  input  wire logic                         rst,
  input  wire logic                         wb_cyc_i,
  input  wire logic                         wb_stb_i,
  input  wire logic                         wb_we_i,
  input  wire logic [tare_pkg::ADR_W-1:0]   wb_adr_i,
  input  wire logic [3:0]                   wb_sel_i,
  input  wire logic [tare_pkg::DATA_W-1:0]  wb_dat_i,
  output logic      [tare_pkg::DATA_W-1:0]  wb_dat_o,
  output logic                              wb_ack_o,
  output logic                              wr_stb,
  output logic      [tare_pkg::ADR_W-1:0]   wr_adr,
  output logic      [tare_pkg::DATA_W-1:0]  wr_dat,
  input  wire logic [tare_pkg::DATA_W-1:0]  rd_dat
);

  logic ack_q;
  logic [tare_pkg::DATA_W-1:0] dat_q;

  // Ack one cycle after the request, dropped the cycle after
  always_ff @(posedge clk_sys)
  begin
    if (rst)
      ack_q <= 1'b0;
    else
      ack_q <= wb_cyc_i && wb_stb_i && !ack_q;
  end

  always_ff @(posedge clk_sys)
  begin
    if (rst)
      dat_q <= tare_pkg::RESET_ZERO;
    else if (wb_cyc_i && wb_stb_i && !wb_we_i && !ack_q)
      dat_q <= rd_dat;
  end

  // Write takes effect at the acking edge; partial writes ignored
  assign wr_stb   = wb_cyc_i && wb_stb_i && wb_we_i && ack_q && (wb_sel_i == tare_pkg::SEL_ALL);
  assign wr_adr   = wb_adr_i;
  assign wr_dat   = wb_dat_i;
  assign wb_ack_o = ack_q;
  assign wb_dat_o = dat_q;

endmodule

/* File: design/setpoint_rescale.sv */
// Rescales the set-point by a unit ratio and clamps it to its range
`timescale 1ns/1ps
module setpoint_rescale #(
  parameter int DW = 32
) (
  input  wire logic signed [DW-1:0] setpoint,
  input  wire logic signed [DW-1:0] ratio,
  output logic signed      [DW-1:0] scaled
);

  logic signed [2*DW-1:0] prod;
  logic signed [2*DW-1:0] shifted;

  assign prod    = setpoint * ratio;
  assign shifted = prod >>> tare_pkg::SCALE_SHIFT;

  always_comb
  begin
    if (shifted > tare_pkg::SP_MAX)
      scaled = tare_pkg::SP_MAX;
    else if (shifted < tare_pkg::SP_MIN)
      scaled = tare_pkg::SP_MIN;
    else
      scaled = shifted[DW-1:0];
  end

endmodule

/* File: test/wb_host_model.sv */
// Host model issuing classic Wishbone parameter writes and reads
`timescale 1ns/1ps
module wb_host_model (
  input  wire logic         clk_sys,
  output logic              cyc,
  output logic              stb,
  output logic              we,
  output logic [7:0]        adr,
  output logic [3:0]        sel,
  output logic [31:0]       dat_w,
  input  wire logic [31:0]  dat_r,
  input  wire logic         ack,
  output logic              stuck
);
  initial
  begin
    cyc   = 1'b0;
    stb   = 1'b0;
    we    = 1'b0;
    adr   = 8'h00;
    sel   = 4'h0;
    dat_w = 32'h0;
    stuck = 1'b0;
  end

  // ****************************************
  // One bus cycle, held until ack or 16 clocks
  // ****************************************
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] q);
    int n;
    @(posedge clk_sys);
    cyc   <= 1'b1;
    stb   <= 1'b1;
    we    <= w;
    adr   <= a;
    sel   <= tare_pkg::SEL_ALL;
    dat_w <= d;
    n = 0;
    do
    begin
      @(posedge clk_sys);
      n++;
    end while (ack !== 1'b1 && n < 16);
    q = dat_r;
    if (ack !== 1'b1)
      stuck <= 1'b1;
    cyc   <= 1'b0;
    stb   <= 1'b0;
    we    <= 1'b0;
    adr   <= ~a;
    dat_w <= ~d;
  endtask
endmodule

/* File: test/tb_top.sv */
// Self-checking bench for the tare and overpressure unit
`timescale 1ns/1ps
`define CHK(nm, e, g) begin checks++; if ((g) !== (e)) begin failures++; \
  $display("unexpected %s exp %h got %h", nm, e, g); end end
module tb_top;
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  logic nv_init = 1'b1;
  logic cyc, stb, we, ack, stuck, sample_valid = 1'b0, out_valid, tare_mark, overpressure;
  logic cmd_a = 1'b0, cmd_b = 1'b0, tare_line = 1'b0;
  logic [7:0] adr;
  logic [3:0] sel;
  logic [31:0] dat_w, dat_r, sample_data = 32'h0, out_data;
  int failures = 0;
  int checks = 0;

  always #4 clk_sys = ~clk_sys;

  wb_host_model u_host (.clk_sys(clk_sys), .cyc(cyc), .stb(stb), .we(we), .adr(adr),
    .sel(sel), .dat_w(dat_w), .dat_r(dat_r), .ack(ack), .stuck(stuck));

  tare_overpressure_unit u_dut (.clk_sys(clk_sys), .rst(rst), .nv_init(nv_init),
    .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
    .wb_dat_i(dat_w), .wb_dat_o(dat_r), .wb_ack_o(ack), .sample_valid(sample_valid),
    .sample_data(sample_data), .pressure_read_cmd_a(cmd_a), .pressure_read_cmd_b(cmd_b),
    .tare_line(tare_line), .out_valid(out_valid), .out_data(out_data),
    .tare_mark(tare_mark), .overpressure(overpressure));

  // ****************************************
  // Shared tasks
  // ****************************************
  task automatic wrap_up();
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  always @(posedge stuck)
  begin
    failures++;
    wrap_up();
  end

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    u_host.xfer(1'b1, a, d, q);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e, input string nm);
    logic [31:0] q;
    u_host.xfer(1'b0, a, 32'h0, q);
    `CHK(nm, e, q)
  endtask

  task automatic smp(input logic [31:0] v, input logic ca, input logic cb,
                     input logic [31:0] e);
    @(posedge clk_sys);
    sample_valid <= 1'b1;
    sample_data  <= v;
    cmd_a        <= ca;
    cmd_b        <= cb;
    @(posedge clk_sys);
    sample_valid <= 1'b0;
    sample_data  <= ~v;
    cmd_a        <= 1'b0;
    cmd_b        <= 1'b0;
    @(posedge clk_sys);
    `CHK("out_valid", 1'b1, out_valid)
    `CHK("out_data", e, out_data)
  endtask

  task automatic do_reset();
    rst <= 1'b1;
    repeat (12) @(posedge clk_sys);
    rst     <= 1'b0;
    nv_init <= 1'b0;
  endtask

  // ****************************************
  // Scenarios
  // ****************************************
  task automatic s_defaults();
    rd(tare_pkg::ADR_STATE, 32'h0, "state");
    rd(tare_pkg::ADR_LOCKOUT, 32'h0, "lockout");
    rd(tare_pkg::ADR_OFFSET, 32'h0, "offset");
    rd(tare_pkg::ADR_SETPOINT, tare_pkg::SP_MAX, "setpoint");
    wr(8'h30, 32'h5);
    rd(8'h30, 32'h0, "unmapped");
  endtask

  task automatic s_tare();
    smp(32'd100, 1'b0, 1'b0, 32'd100);
    wr(tare_pkg::ADR_STATE, tare_pkg::WR_TARE_REQ);
    rd(tare_pkg::ADR_STATE, 32'h1, "state");
    smp(32'd500, 1'b0, 1'b0, 32'd500);
    rd(tare_pkg::ADR_STATE, 32'h2, "state");
    rd(tare_pkg::ADR_OFFSET, 32'd500, "offset");
    smp(32'd700, 1'b0, 1'b0, 32'd200);
    wr(tare_pkg::ADR_STATE, 32'h3);
    rd(tare_pkg::ADR_STATE, 32'h2, "state");
  endtask

  task automatic s_retare();
    wr(tare_pkg::ADR_OFFSET, 32'd50);
    smp(32'd300, 1'b0, 1'b0, 32'd250);
    wr(tare_pkg::ADR_OFFSET, 32'h0098_9680);
    rd(tare_pkg::ADR_OFFSET, 32'd50, "offset");
    wr(tare_pkg::ADR_STATE, tare_pkg::WR_TARE_REQ);
    smp(32'd1000, 1'b0, 1'b0, 32'd1000);
    rd(tare_pkg::ADR_OFFSET, 32'd1000, "offset");
    smp(32'd1200, 1'b0, 1'b0, 32'd200);
    wr(tare_pkg::ADR_STATE, tare_pkg::WR_TARE_OFF);
    smp(32'd1200, 1'b0, 1'b0, 32'd1200);
  endtask

  task automatic s_lockout();
    wr(tare_pkg::ADR_LOCKOUT, 32'h1);
    wr(tare_pkg::ADR_STATE, tare_pkg::WR_TARE_REQ);
    @(posedge clk_sys);
    tare_line <= 1'b1;
    @(posedge clk_sys);
    tare_line <= 1'b0;
    rd(tare_pkg::ADR_STATE, 32'h0, "state");
    wr(tare_pkg::ADR_LOCKOUT, 32'h0);
    wr(tare_pkg::ADR_STATE, tare_pkg::WR_TARE_REQ);
    wr(tare_pkg::ADR_LOCKOUT, 32'h1);
    smp(32'd40, 1'b0, 1'b0, 32'd40);
    wr(tare_pkg::ADR_STATE, tare_pkg::WR_TARE_OFF);
    rd(tare_pkg::ADR_STATE, 32'h2, "state");
    wr(tare_pkg::ADR_LOCKOUT, 32'h0);
    wr(tare_pkg::ADR_STATE, tare_pkg::WR_TARE_OFF);
    rd(tare_pkg::ADR_STATE, 32'h0, "state");
    @(posedge clk_sys);
    tare_line <= 1'b1;
    @(posedge clk_sys);
    tare_line <= 1'b0;
    rd(tare_pkg::ADR_STATE, 32'h1, "state");
    wr(tare_pkg::ADR_STATE, tare_pkg::WR_TARE_OFF);
  endtask

  task automatic s_indicate();
    wr(tare_pkg::ADR_INDICATE, 32'h1);
    wr(tare_pkg::ADR_STATE, tare_pkg::WR_TARE_REQ);
    smp(32'd10, 1'b0, 1'b0, 32'd10);
    smp(32'd30, 1'b0, 1'b0, 32'd20);
    `CHK("tare_mark", 1'b1, tare_mark)
    rd(tare_pkg::ADR_INDICATE, 32'h1, "indicate");
    rd(tare_pkg::ADR_STATUS, 32'h2, "status");
    rd(tare_pkg::ADR_SAMPLE, 32'd20, "sample");
    wr(tare_pkg::ADR_INDICATE, 32'h0);
    smp(32'd40, 1'b0, 1'b0, 32'd30);
    `CHK("tare_mark", 1'b0, tare_mark)
    wr(tare_pkg::ADR_STATE, tare_pkg::WR_TARE_OFF);
  endtask

  task automatic s_over();
    wr(tare_pkg::ADR_SETPOINT, 32'd1000);
    smp(32'd2000, 1'b0, 1'b0, 32'd2000);
    `CHK("overpressure", 1'b0, overpressure)
    smp(32'd2000, 1'b1, 1'b0, 32'd2000);
    `CHK("overpressure", 1'b1, overpressure)
    smp(32'd999, 1'b0, 1'b1, 32'd999);
    `CHK("overpressure", 1'b0, overpressure)
    smp(32'd2000, 1'b0, 1'b0, 32'd2000);
    `CHK("overpressure", 1'b0, overpressure)
    @(posedge clk_sys);
    cmd_b <= 1'b1;
    @(posedge clk_sys);
    cmd_b <= 1'b0;
    smp(32'd2000, 1'b0, 1'b0, 32'd2000);
    `CHK("overpressure", 1'b1, overpressure)
    wr(tare_pkg::ADR_MODE, 32'h1);
    rd(tare_pkg::ADR_MODE, 32'h1, "mode");
    smp(32'd1000, 1'b0, 1'b0, 32'd1000);
    `CHK("overpressure", 1'b1, overpressure)
    smp(32'd999, 1'b0, 1'b0, 32'd999);
    `CHK("overpressure", 1'b0, overpressure)
    wr(tare_pkg::ADR_MODE, 32'h0);
    wr(tare_pkg::ADR_UNIT, 32'h0002_0000);
    rd(tare_pkg::ADR_SETPOINT, 32'd2000, "setpoint");
    wr(tare_pkg::ADR_UNIT, 32'h0);
    rd(tare_pkg::ADR_UNIT, 32'h0002_0000, "unit");
    wr(tare_pkg::ADR_SETPOINT, 32'h0098_9680);
    rd(tare_pkg::ADR_SETPOINT, 32'd2000, "setpoint");
  endtask

  task automatic s_persist();
    wr(tare_pkg::ADR_PERSIST, 32'h1);
    wr(tare_pkg::ADR_STATE, tare_pkg::WR_TARE_REQ);
    smp(32'd777, 1'b0, 1'b0, 32'd777);
    do_reset();
    rd(tare_pkg::ADR_OFFSET, 32'd777, "offset");
    rd(tare_pkg::ADR_PERSIST, 32'h1, "persist");
    rd(tare_pkg::ADR_STATE, 32'h0, "state");
    wr(tare_pkg::ADR_PERSIST, 32'h0);
    do_reset();
    rd(tare_pkg::ADR_OFFSET, 32'h0, "offset");
  endtask

  initial
  begin
    do_reset();
    s_defaults();
    s_tare();
    s_retare();
    s_lockout();
    s_indicate();
    s_over();
    s_persist();
    wrap_up();
  end
endmodule
